// file: ldgp_pkg.sv
package ldgp_pkg;

  // ---------------------------------------------------------------
  // apb register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DUTY = 8'h04;
  localparam logic [7:0] ADDR_BIN_GAIN = 8'h08;
  localparam logic [7:0] ADDR_DERATE = 8'h0C;
  localparam logic [7:0] ADDR_SLOPE = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_GAIN = 8'h18;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_FREQ_LSB = 4;
  localparam int DERATE_START_LSB = 0;
  localparam int DERATE_FLOOR_LSB = 4;

  // ---------------------------------------------------------------
  // dimming generator
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int PWM_STEPS = 200;
  localparam logic [7:0] DUTY_MAX = 8'hC8;
  localparam int FREQ_HZ_0 = 200;
  localparam int FREQ_HZ_1 = 250;
  localparam int FREQ_HZ_2 = 300;
  localparam int FREQ_HZ_3 = 350;
  localparam logic [11:0] STEP_CYC_0 = 12'((CLK_HZ + FREQ_HZ_0 * PWM_STEPS / 2) / (FREQ_HZ_0 * PWM_STEPS));
  localparam logic [11:0] STEP_CYC_1 = 12'((CLK_HZ + FREQ_HZ_1 * PWM_STEPS / 2) / (FREQ_HZ_1 * PWM_STEPS));
  localparam logic [11:0] STEP_CYC_2 = 12'((CLK_HZ + FREQ_HZ_2 * PWM_STEPS / 2) / (FREQ_HZ_2 * PWM_STEPS));
  localparam logic [11:0] STEP_CYC_3 = 12'((CLK_HZ + FREQ_HZ_3 * PWM_STEPS / 2) / (FREQ_HZ_3 * PWM_STEPS));

  // ---------------------------------------------------------------
  // gains in thousandths, voltages in millivolts
  // ---------------------------------------------------------------
  localparam logic [9:0] GAIN_ONE = 10'h3E8;
  localparam logic [9:0] BIN_STEP = 10'h019;
  localparam logic [9:0] FLOOR_BASE = 10'h384;
  localparam logic [9:0] FLOOR_STEP = 10'h064;
  localparam logic [15:0] START_BASE_MV = 16'h1D4C;
  localparam logic [15:0] START_STEP_MV = 16'h01F4;
  localparam int SLOPE_DIV = 80;

  // ---------------------------------------------------------------
  // bin thresholds on an 8-bit fraction of supply
  // ---------------------------------------------------------------
  localparam logic [7:0] BIN1_MIN = 8'h9F;
  localparam logic [7:0] BIN2_MIN = 8'h74;
  localparam logic [7:0] BIN3_MIN = 8'h40;

  typedef struct packed {
    logic [3:0][4:0] slope;
    logic [3:0][3:0] bin_gain;
    logic [2:0] floor_code;
    logic [2:0] start_code;
  } ldgp_cfg_t;

endpackage : ldgp_pkg

// file: ldgp_pwm_gen.sv
`timescale 1ns/1ps
module ldgp_pwm_gen
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // settings
  input wire logic [1:0] freq_sel,
  input wire logic [7:0] duty,
  // dimming signal
  output logic dim_out,
  output logic period_start
);

  logic [11:0] step_cnt;
  logic [11:0] step_len;
  logic [7:0] pos;
  logic [7:0] duty_q;
  logic [1:0] freq_q;
  logic step_end;

  // ---------------------------------------------------------------
  // step length per frequency
  // ---------------------------------------------------------------
  always_comb
  begin
    unique case (freq_q)
      2'b00: step_len = ldgp_pkg::STEP_CYC_0;
      2'b01: step_len = ldgp_pkg::STEP_CYC_1;
      2'b10: step_len = ldgp_pkg::STEP_CYC_2;
      2'b11: step_len = ldgp_pkg::STEP_CYC_3;
    endcase
  end

  assign step_end = (step_cnt == step_len - 12'h001);
  assign period_start = step_end && (pos == ldgp_pkg::DUTY_MAX - 8'h01);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      step_cnt <= 12'h000;
    else if (step_end)
      step_cnt <= 12'h000;
    else
      step_cnt <= step_cnt + 12'h001;
  end

  // 200-step period position
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pos <= 8'h00;
    else if (period_start)
      pos <= 8'h00;
    else if (step_end)
      pos <= pos + 8'h01;
  end

  // settings taken only at a period boundary
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      duty_q <= 8'h00;
      freq_q <= 2'b00;
    end
    else if (period_start)
    begin
      duty_q <= (duty > ldgp_pkg::DUTY_MAX) ? ldgp_pkg::DUTY_MAX : duty;
      freq_q <= freq_sel;
    end
  end

  // high while position is below duty, half percent per code
  assign dim_out = (pos < duty_q);

  property p_zero_off;
    @(posedge pclk) disable iff (!presetn)
    (duty_q == 8'h00) |-> !dim_out;
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("duty zero gave on");

  property p_settings_hold;
    @(posedge pclk) disable iff (!presetn)
    !$past(period_start) |-> $stable(duty_q) && $stable(freq_q);
  endproperty
  a_settings_hold: assert property (p_settings_hold) else $error("settings changed mid period");

endmodule : ldgp_pwm_gen

// file: ldgp_gain_calc.sv
`timescale 1ns/1ps
module ldgp_gain_calc
(
  // settings and operating point
  input wire ldgp_pkg::ldgp_cfg_t cfg,
  input wire logic [1:0] bin_idx,
  input wire logic [15:0] supply_mv,
  input wire logic [9:0] thermal_gain,
  // gains in thousandths
  output logic [9:0] bin_gain,
  output logic [9:0] supply_gain,
  output logic [9:0] limit_gain
);

  logic [15:0] start_mv;
  logic [9:0] floor_gain;
  logic [5:0] slope_mult;
  logic [21:0] drop_raw;
  logic [9:0] drop;

  function automatic logic [9:0] min2(input logic [9:0] a, input logic [9:0] b);
    min2 = (a < b) ? a : b;
  endfunction : min2

  assign bin_gain = ldgp_pkg::GAIN_ONE - 10'(cfg.bin_gain[bin_idx] * ldgp_pkg::BIN_STEP);
  assign floor_gain = (cfg.floor_code == 3'b000) ? ldgp_pkg::GAIN_ONE :
    ldgp_pkg::FLOOR_BASE - 10'(cfg.floor_code * ldgp_pkg::FLOOR_STEP);
  assign start_mv = ldgp_pkg::START_BASE_MV + 16'(cfg.start_code * ldgp_pkg::START_STEP_MV);
  assign slope_mult = {1'b0, cfg.slope[bin_idx]} + 6'h01;

  // gain falls from bin gain at start by slope per volt, clamped at floor
  always_comb
  begin
    drop_raw = (22'(slope_mult) * 22'(start_mv - supply_mv)) / 22'(ldgp_pkg::SLOPE_DIV);
    drop = (drop_raw > 22'(ldgp_pkg::GAIN_ONE)) ? ldgp_pkg::GAIN_ONE : drop_raw[9:0];
    if (supply_mv >= start_mv)
      supply_gain = bin_gain;
    else if ({1'b0, drop} + {1'b0, floor_gain} >= {1'b0, bin_gain})
      supply_gain = floor_gain;
    else
      supply_gain = bin_gain - drop;
  end

  assign limit_gain = min2(min2(bin_gain, supply_gain), thermal_gain);

endmodule : ldgp_gain_calc

// file: ldgp_top.sv
`timescale 1ns/1ps
module ldgp_top
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // dimming pins
  input wire logic dim_source_select_n,
  input wire logic enable_dim_input,
  output logic dim_switch_drive,
  // analog operating point, digitised
  input wire logic [7:0] bin_select_pin,
  input wire logic [15:0] supply_mv,
  input wire logic [9:0] thermal_gain,
  // current limit
  output logic [1:0] active_bin,
  output logic [9:0] current_limit_gain,
  output logic internal_dim_active
);

  logic internal_dim_enable;
  logic [1:0] dim_frequency_select;
  logic [7:0] duty_code;
  ldgp_pkg::ldgp_cfg_t cfg;
  logic [1:0] next_bin;
  logic [9:0] bin_gain;
  logic [9:0] supply_gain;
  logic [9:0] limit_gain;
  logic [9:0] supply_gain_q;
  logic pwm_dim;
  logic period_start;
  logic wr_en;
  logic access;
  logic addr_ok;
  logic [31:0] rd_word;

  // ---------------------------------------------------------------
  // apb slave: answers in the second access cycle
  // ---------------------------------------------------------------
  assign access = psel && penable;
  assign wr_en = access && pready && pwrite && addr_ok;

  always_comb
  begin
    addr_ok = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (paddr)
      ldgp_pkg::ADDR_CTRL:
      begin
        rd_word[ldgp_pkg::CTRL_EN_BIT] = internal_dim_enable;
        rd_word[ldgp_pkg::CTRL_FREQ_LSB +: 2] = dim_frequency_select;
      end
      ldgp_pkg::ADDR_DUTY: rd_word[7:0] = duty_code;
      ldgp_pkg::ADDR_BIN_GAIN: rd_word[15:0] = cfg.bin_gain;
      ldgp_pkg::ADDR_DERATE:
      begin
        rd_word[ldgp_pkg::DERATE_START_LSB +: 3] = cfg.start_code;
        rd_word[ldgp_pkg::DERATE_FLOOR_LSB +: 3] = cfg.floor_code;
      end
      ldgp_pkg::ADDR_SLOPE:
        rd_word = {3'b000, cfg.slope[3], 3'b000, cfg.slope[2],
                   3'b000, cfg.slope[1], 3'b000, cfg.slope[0]};
      ldgp_pkg::ADDR_STATUS:
        rd_word = {27'h000_0000, dim_switch_drive, internal_dim_active, 1'b0, active_bin};
      ldgp_pkg::ADDR_GAIN:
        rd_word = {6'h00, supply_gain_q, 6'h00, current_limit_gain};
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= access && !pready;
      prdata <= (access && !pready && !pwrite) ? rd_word : 32'h0000_0000;
      pslverr <= access && !pready && !addr_ok;
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      internal_dim_enable <= 1'b0;
      dim_frequency_select <= 2'b00;
      duty_code <= 8'h00;
    end
    else if (wr_en && paddr == ldgp_pkg::ADDR_CTRL)
    begin
      internal_dim_enable <= pwdata[ldgp_pkg::CTRL_EN_BIT];
      dim_frequency_select <= pwdata[ldgp_pkg::CTRL_FREQ_LSB +: 2];
    end
    else if (wr_en && paddr == ldgp_pkg::ADDR_DUTY)
      duty_code <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg <= '0;
    else if (wr_en && paddr == ldgp_pkg::ADDR_BIN_GAIN)
      cfg.bin_gain <= pwdata[15:0];
    else if (wr_en && paddr == ldgp_pkg::ADDR_DERATE)
    begin
      cfg.start_code <= pwdata[ldgp_pkg::DERATE_START_LSB +: 3];
      cfg.floor_code <= pwdata[ldgp_pkg::DERATE_FLOOR_LSB +: 3];
    end
    else if (wr_en && paddr == ldgp_pkg::ADDR_SLOPE)
    begin
      cfg.slope[0] <= pwdata[4:0];
      cfg.slope[1] <= pwdata[12:8];
      cfg.slope[2] <= pwdata[20:16];
      cfg.slope[3] <= pwdata[28:24];
    end
  end

  // ---------------------------------------------------------------
  // dimming source and switch drive
  // ---------------------------------------------------------------
  ldgp_pwm_gen u_pwm
  (
    .pclk(pclk),
    .presetn(presetn),
    .freq_sel(dim_frequency_select),
    .duty(duty_code),
    .dim_out(pwm_dim),
    .period_start(period_start)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      internal_dim_active <= 1'b0;
      dim_switch_drive <= 1'b0;
    end
    else
    begin
      internal_dim_active <= internal_dim_enable || !dim_source_select_n;
      // enable input is only an enable when internal dimming runs
      dim_switch_drive <= (internal_dim_enable || !dim_source_select_n) ?
        (pwm_dim && enable_dim_input) : enable_dim_input;
    end
  end

  // ---------------------------------------------------------------
  // bin decode and current limit
  // ---------------------------------------------------------------
  always_comb
  begin
    if (bin_select_pin >= ldgp_pkg::BIN1_MIN)
      next_bin = 2'd0;
    else if (bin_select_pin >= ldgp_pkg::BIN2_MIN)
      next_bin = 2'd1;
    else if (bin_select_pin >= ldgp_pkg::BIN3_MIN)
      next_bin = 2'd2;
    else
      next_bin = 2'd3;
  end

  ldgp_gain_calc u_gain
  (
    .cfg(cfg),
    .bin_idx(active_bin),
    .supply_mv(supply_mv),
    .thermal_gain(thermal_gain),
    .bin_gain(bin_gain),
    .supply_gain(supply_gain),
    .limit_gain(limit_gain)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      active_bin <= 2'd0;
      current_limit_gain <= ldgp_pkg::GAIN_ONE;
      supply_gain_q <= ldgp_pkg::GAIN_ONE;
    end
    else
    begin
      active_bin <= next_bin;
      current_limit_gain <= limit_gain;
      supply_gain_q <= supply_gain;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_source_select;
    @(posedge pclk) disable iff (!presetn)
    internal_dim_enable |=> internal_dim_active;
  endproperty
  a_source_select: assert property (p_source_select) else $error("enable bit did not force internal");

  property p_drive_follows;
    @(posedge pclk) disable iff (!presetn)
    (presetn && !internal_dim_enable && dim_source_select_n) |=>
      (dim_switch_drive == $past(enable_dim_input));
  endproperty
  a_drive_follows: assert property (p_drive_follows) else $error("external drive mismatch");

  property p_limit_min;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> current_limit_gain <= $past(bin_gain) && current_limit_gain <= $past(thermal_gain);
  endproperty
  a_limit_min: assert property (p_limit_min) else $error("limit above a factor");

  property p_bin1;
    @(posedge pclk) disable iff (!presetn)
    (bin_select_pin >= ldgp_pkg::BIN1_MIN) |=> (active_bin == 2'd0);
  endproperty
  a_bin1: assert property (p_bin1) else $error("bin1 decode wrong");

  property p_bin_gain_code;
    @(posedge pclk) disable iff (!presetn)
    (cfg.bin_gain[active_bin] == 4'hF) |-> (bin_gain == 10'h271);
  endproperty
  a_bin_gain_code: assert property (p_bin_gain_code) else $error("code 15 gain not 0.625");

  property p_above_start;
    @(posedge pclk) disable iff (!presetn)
    (supply_mv >= 16'h2AF8) |-> (supply_gain == bin_gain);
  endproperty
  a_above_start: assert property (p_above_start) else $error("derating above start");

  property p_apb_answer;
    @(posedge pclk) disable iff (!presetn)
    (access && !pready) |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing wrong");

  property p_floor_bound;
    @(posedge pclk) disable iff (!presetn)
    (cfg.floor_code == 3'b111 && bin_gain > 10'h0C8) |-> (supply_gain >= 10'h0C8);
  endproperty
  a_floor_bound: assert property (p_floor_bound) else $error("gain under floor");

endmodule : ldgp_top

// file: ldgp_host.sv
`timescale 1ns/1ps
module ldgp_host
(
  // clock
  input wire logic pclk,
  // apb master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // apb answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ---------------------------------------------------------------
  // idle bus
  // ---------------------------------------------------------------
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // ---------------------------------------------------------------
  // one transfer, request held until pready
  // ---------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : ldgp_host

// file: ldgp_top_test.sv
`timescale 1ns/1ps
module ldgp_top_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr, bin_select_pin;
  logic [31:0] pwdata, prdata, r;
  logic dim_source_select_n, enable_dim_input, dim_switch_drive, internal_dim_active;
  logic [15:0] supply_mv;
  logic [9:0] thermal_gain, current_limit_gain;
  logic [1:0] active_bin;
  logic [7:0] pins [4] = '{8'h9F, 8'h74, 8'h40, 8'h3F};
  logic [9:0] gains [4] = '{10'h3E8, 10'h39D, 10'h320, 10'h271};
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;

  ldgp_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dim_source_select_n(dim_source_select_n),
    .enable_dim_input(enable_dim_input), .dim_switch_drive(dim_switch_drive),
    .bin_select_pin(bin_select_pin), .supply_mv(supply_mv), .thermal_gain(thermal_gain),
    .active_bin(active_bin), .current_limit_gain(current_limit_gain),
    .internal_dim_active(internal_dim_active));

  ldgp_host host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ---------------------------------------------------------------
  // clock, timeout and helpers
  // ---------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      conclude();
    end
  end

  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] x);
    checked++;
    if (seen !== x)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, x, seen);
    end
  endtask : check

  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
    host_u.xfer(1'b0, a, 32'h0000_0000, r, e);
    check(n, r, x);
  endtask : rd

  task automatic lim(input string n, input logic [9:0] x);
    repeat (3) @(posedge pclk);
    check(n, {22'h0, current_limit_gain}, {22'h0, x});
  endtask : lim

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    dim_source_select_n = 1'b1;
    enable_dim_input = 1'b1;
    bin_select_pin = 8'hC8;
    supply_mv = 16'h4E20;
    thermal_gain = 10'h3E8;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) rd("config reset", 8'(i * 4), 32'h0000_0000);
    rd("unmapped", 8'h1C, 32'h0000_0000);
    check("pslverr", {31'h0, e}, 32'h0000_0001);
    for (int f = 0; f < 4; f++)
    begin
      wr(ldgp_pkg::ADDR_CTRL, 32'(f << 4));
      rd("freq", ldgp_pkg::ADDR_CTRL, 32'(f << 4));
    end
    wr(ldgp_pkg::ADDR_DUTY, 32'h0000_00C8);
    rd("duty", ldgp_pkg::ADDR_DUTY, 32'h0000_00C8);
    wr(ldgp_pkg::ADDR_DUTY, 32'h0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      wr(ldgp_pkg::ADDR_CTRL, 32'(i & 1));
      @(posedge pclk);
      dim_source_select_n <= i[1];
      repeat (3) @(posedge pclk);
      check("internal", {31'h0, internal_dim_active}, 32'(i != 2));
      check("drive", {31'h0, dim_switch_drive}, 32'(i == 2));
    end
    wr(ldgp_pkg::ADDR_CTRL, 32'h0000_0000);
    rd("status", ldgp_pkg::ADDR_STATUS, 32'h0000_0010);
    @(posedge pclk);
    enable_dim_input <= 1'b0;
    repeat (3) @(posedge pclk);
    check("drive off", {31'h0, dim_switch_drive}, 32'h0000_0000);
    enable_dim_input <= 1'b1;
    wr(ldgp_pkg::ADDR_BIN_GAIN, 32'h0000_F830);
    for (int b = 0; b < 4; b++)
    begin
      @(posedge pclk);
      bin_select_pin <= pins[b];
      lim("bin gain", gains[b]);
      check("bin", {30'h0, active_bin}, 32'(b));
    end
    @(posedge pclk);
    bin_select_pin <= 8'h9F;
    thermal_gain <= 10'h1F4;
    lim("thermal", 10'h1F4);
    thermal_gain <= 10'h3E8;
    wr(ldgp_pkg::ADDR_DERATE, 32'h0000_0037);
    wr(ldgp_pkg::ADDR_SLOPE, 32'h0000_0007);
    supply_mv <= 16'h2EE0;
    lim("above start", 10'h3E8);
    supply_mv <= 16'h1388;
    lim("below stop", 10'h258);
    supply_mv <= 16'h2710;
    lim("ramp", 10'h384);
    rd("gain reg", ldgp_pkg::ADDR_GAIN, 32'h0384_0384);
    wr(ldgp_pkg::ADDR_SLOPE, 32'h0000_001F);
    supply_mv <= 16'h0000;
    for (int k = 0; k < 8; k++)
    begin
      wr(ldgp_pkg::ADDR_DERATE, 32'(k << 4));
      lim("floor", (k == 0) ? 10'h3E8 : 10'(900 - 100 * k));
    end
    wr(ldgp_pkg::ADDR_SLOPE, 32'h0000_0000);
    for (int k = 0; k < 8; k++)
    begin
      wr(ldgp_pkg::ADDR_DERATE, 32'(k | 8'h70));
      supply_mv <= 16'(7500 + 500 * k);
      lim("at start", 10'h3E8);
      supply_mv <= 16'(7420 + 500 * k);
      lim("under start", 10'h3E7);
    end
    wr(ldgp_pkg::ADDR_DERATE, 32'h0000_0070);
    supply_mv <= 16'h1A2C;
    for (int s = 0; s < 32; s++)
    begin
      wr(ldgp_pkg::ADDR_SLOPE, 32'(s));
      lim("slope", 10'(990 - 10 * s));
    end
    wr(ldgp_pkg::ADDR_SLOPE, 32'h1F00_0000);
    lim("own slope", 10'h3DE);
    @(posedge pclk);
    bin_select_pin <= 8'h3F;
    lim("bin4 slope", 10'h131);
    conclude();
  end
endmodule : ldgp_top_test
